// ---- adc_sequencer_control_bench.sv ----
`timescale 1ns/1ns
module adc_sequencer_control_bench;
  import asc_pkg::*;
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
  logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ext_trg = 1'b0, sleep = 1'b0, slow = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o, req, abort, done, evt, busy, vref;
  logic [2:0] ch;
  logic [9:0] cdata;
  logic [6:0] salt = 7'h00;
  logic [7:0] rd;
  int fail_count = 0, check_count = 0, cyc_n = 0, req_n = 0, evt_n = 0, abort_n = 0;
  int seq[$];
  int first, v, n;
  asc_ctrl i_dut (.clk_sys_i(clk), .srst_i(srst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .conv_req_o(req), .conv_ch_o(ch),
    .conv_abort_o(abort), .conv_done_i(done), .conv_data_i(cdata), .reference_power_on_o(vref),
    .ext_trigger_i(ext_trg), .light_sleep_state_i(sleep), .conv_end_evt_o(evt), .conv_busy_flag_o(busy));
  asc_core_model i_core (.clk_sys_i(clk), .srst_i(srst), .req_i(req), .ch_i(ch), .abort_i(abort),
    .salt_i(salt), .slow_i(slow), .done_o(done), .data_o(cdata));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc_n++;
    if (req === 1'b1) begin
      req_n++;
      seq.push_back(ch);
    end
    if (evt === 1'b1) evt_n++;
    if (abort === 1'b1) abort_n++;
    if (cyc_n == 60000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= {3'($urandom), 1'b1};
    wdat <= {24'($urandom), d};
    @(posedge clk);
    while (ack_o !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    rd = dat_o[7:0];
    `CHK("ack", 1, k < 50)
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic wait_end();
    int k;
    k = 0;
    @(posedge clk);
    @(posedge clk);
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    // one more edge so the monitor has counted the end event
    @(posedge clk);
    `CHK("busy end", 1, k < 2000)
  endtask : wait_end
  initial begin
    void'($urandom(32'h1ba1_43b6));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    wb(0, MODE0_IDX, 0);
    `CHK("mode0 reset", 8'h00, rd)
    wb(0, MODE1_IDX, 0);
    `CHK("mode1 reset", 8'h00, rd)
    `CHK("vref reset", 1'b0, vref)
    for (int p = 0; p < 4; p++) begin
      wb(0, RES0_LOW_IDX + 10'(2 * p), 0);
      `CHK("stored reset", 1'b0, rd[0])
    end
    wb(0, 10'h2a8, 0);
    `CHK("unmapped", 8'h00, rd)
    wb(1, MODE1_IDX, 8'hcf);
    wb(0, MODE1_IDX, 0);
    `CHK("mode1 back", 8'hcf, rd)
    `CHK("vref on", 1'b1, vref)
    $display("test registers done");
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 8; c++) begin
        salt <= 7'($urandom);
        slow <= 1'($urandom);
        wb(1, MODE1_IDX, 8'(c));
        seq.delete();
        evt_n = 0;
        wb(1, MODE0_IDX, 8'(2 * s + 1));
        wb(0, MODE0_IDX, 0);
        `CHK("busy flag", 1'b1, rd[6])
        wait_end();
        first = (s == 0) ? c : (c >= 4 ? 4 : 0);
        `CHK("conv count", c - first + 1, seq.size())
        for (int k = first; k <= c && k - first < seq.size(); k++) begin
          `CHK("conv order", k, seq[k - first])
        end
        `CHK("end events", 1, evt_n)
        wb(0, MODE0_IDX, 0);
        `CHK("mode0 end", 8'(8'h80 + 2 * s), rd)
        for (int k = first; k <= c; k++) begin
          v = k * 128 + int'(salt);
          wb(0, RES0_LOW_IDX + 10'(2 * (k % 4)), 0);
          `CHK("result low", 8'((v % 4) * 64 + 1), rd)
          wb(0, RES0_HIGH_IDX + 10'(2 * (k % 4)), 0);
          `CHK("result high", 8'(v / 4), rd)
        end
      end
    end
    $display("test single and scan done");
    wb(1, MODE1_IDX, 8'h05);
    req_n = 0;
    ext_trg <= 1'b1;
    repeat (20) @(posedge clk);
    ext_trg <= 1'b0;
    `CHK("trigger off", 0, req_n)
    wb(1, MODE1_IDX, 8'h0d);
    ext_trg <= 1'b1;
    repeat (20) @(posedge clk);
    ext_trg <= 1'b0;
    wait_end();
    // scan still selected: channel 5 converts inputs 4 and 5
    `CHK("trigger on", 2, req_n)
    $display("test trigger done");
    slow <= 1'b1;
    wb(1, MODE1_IDX, 8'h03);
    evt_n = 0;
    abort_n = 0;
    wb(1, MODE0_IDX, 8'h01);
    sleep <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("sleep abort", 1, abort_n > 0)
    `CHK("sleep busy", 1'b0, busy)
    sleep <= 1'b0;
    wb(1, MODE1_IDX, 8'h43);
    abort_n = 0;
    wb(1, MODE0_IDX, 8'h01);
    sleep <= 1'b1;
    wait_end();
    sleep <= 1'b0;
    `CHK("sleep operate", 1, evt_n)
    `CHK("no abort", 0, abort_n)
    $display("test sleep done");
    for (int itm = 0; itm < 2; itm++) begin
      wb(1, MODE1_IDX, 8'h01);
      req_n = 0;
      evt_n = 0;
      wb(1, MODE0_IDX, 8'(itm * 8 + 7));
      n = 0;
      while (req_n < 6 && n < 1000) begin
        @(posedge clk);
        n++;
      end
      wb(1, MODE0_IDX, 8'(itm * 8 + 2));
      wait_end();
      `CHK("whole passes", 0, req_n % 2)
      `CHK("repeat events", itm ? req_n : req_n / 2, evt_n)
    end
    $display("test repeat done");
    conclude();
  end
endmodule : adc_sequencer_control_bench

// ---- asc_core_model.sv ----
`timescale 1ns/1ns
module asc_core_model (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic req_i,
  input wire logic [2:0] ch_i,
  input wire logic abort_i,
  input wire logic [6:0] salt_i,
  input wire logic slow_i,
  output logic done_o,
  output logic [9:0] data_o
);
  int wait_q;
  logic [2:0] ch_q;
  initial begin
    done_o = 1'b0;
    data_o = 10'h155;
    wait_q = -1;
    ch_q = 3'h0;
  end
  // result is input number over salt; data toggles outside the done pulse
  always @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (srst_i || abort_i) begin
      wait_q <= -1;
    end else if (req_i) begin
      wait_q <= slow_i ? 2 + $urandom_range(7) : 0;
      ch_q <= ch_i;
    end else if (wait_q == 0) begin
      done_o <= 1'b1;
      data_o <= {ch_q, salt_i};
      wait_q <= -1;
    end else if (wait_q > 0) begin
      wait_q <= wait_q - 1;
    end
  end
endmodule : asc_core_model

// ---- asc_ctrl.sv ----
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns
module asc_ctrl
  import asc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [asc_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // conversion core side
  output logic conv_req_o,
  output logic [asc_pkg::CH_W-1:0] conv_ch_o,
  output logic conv_abort_o,
  input wire logic conv_done_i,
  input wire logic [asc_pkg::RES_W-1:0] conv_data_i,
  output logic reference_power_on_o,
  input wire logic ext_trigger_i,
  input wire logic light_sleep_state_i,
  output logic conv_end_evt_o,
  output logic conv_busy_flag_o
);
  import asc_pkg::*;

  typedef struct packed {
    asc_fsm_t fsm;
    logic [CH_W-1:0] cur;
    logic conv_busy_flag;
    logic conv_end_flag;
    logic go;
    logic repeat_irq_timing;
    logic repeat_mode;
    logic scan_mode;
    logic reference_power_on;
    logic idle_operate_sel;
    logic ext_trigger_enable;
    logic [CH_W-1:0] channel_sel;
    logic ext_prev;
    logic evt;
    logic req;
    logic abort;
    logic pend;
    logic ack;
    logic [7:0] dat;
  } asc_state_t;

  asc_state_t st;
  asc_state_t next_st;

  logic [CH_W-1:0] first_ch;
  logic [CH_W-1:0] next_ch;
  logic last_ch;
  logic [RES_W-1:0] res_rd;
  logic [PAIRS-1:0] res_stored;
  logic [9:0] idx;
  logic is_res;
  logic [1:0] pair;
  logic wr_acc;
  logic rd_acc;
  logic sw_start;
  logic ext_start;
  logic abort_now;
  logic done_now;
  logic store_en;
  logic clr_en;

  asc_scan_step u_step (
    .ch_i(st.channel_sel),
    .scan_i(st.scan_mode),
    .cur_i(st.cur),
    .first_o(first_ch),
    .next_o(next_ch),
    .last_o(last_ch)
  );

  asc_result_store #(
    .WIDTH(RES_W),
    .DEPTH(PAIRS)
  ) u_store (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .wr_en_i(store_en),
    .wr_idx_i(st.cur[1:0]),
    .wr_data_i(conv_data_i),
    .clr_en_i(clr_en),
    .clr_idx_i(pair),
    .rd_idx_i(pair),
    .rd_data_o(res_rd),
    .stored_o(res_stored)
  );

  // address decode; access is carried out one cycle after the request is seen
  always_comb begin
    idx = adr_i[ADR_W-1:2];
    is_res = (idx[9:3] == RES0_LOW_IDX[9:3]);
    pair = idx[2:1];
    wr_acc = st.pend && we_i && sel_i[0];
    rd_acc = st.pend && !we_i;
    sw_start = wr_acc && idx == MODE0_IDX && dat_i[M0_START];
    ext_start = st.ext_trigger_enable && ext_trigger_i && !st.ext_prev;
    abort_now = light_sleep_state_i && !st.idle_operate_sel;
    done_now = st.fsm == ASC_WAIT && conv_done_i && !abort_now;
    store_en = done_now;
    clr_en = rd_acc && is_res && idx[0];
  end

  always_comb begin
    next_st = st;
    next_st.evt = 1'b0;
    next_st.req = 1'b0;
    next_st.abort = 1'b0;
    next_st.ext_prev = ext_trigger_i;
    // bus slave: take, then answer, then drop ack
    if (st.ack) begin
      next_st.ack = 1'b0;
    end
    if (cyc_i && stb_i && !st.ack && !st.pend) begin
      next_st.pend = 1'b1;
    end
    if (st.pend) begin
      next_st.pend = 1'b0;
      next_st.ack = 1'b1;
      next_st.dat = 8'h00;
      if (rd_acc) begin
        if (is_res && !idx[0]) begin
          next_st.dat[7:LOW_LSB_POS] = res_rd[1:0];
          next_st.dat[LOW_STORED] = res_stored[pair];
        end else if (is_res) begin
          next_st.dat = res_rd[RES_W-1:2];
        end else if (idx == MODE0_IDX) begin
          next_st.dat[M0_END] = st.conv_end_flag;
          next_st.dat[M0_BUSY] = st.conv_busy_flag;
          next_st.dat[M0_ITM] = st.repeat_irq_timing;
          next_st.dat[M0_REPEAT] = st.repeat_mode;
          next_st.dat[M0_SCAN] = st.scan_mode;
        end else if (idx == MODE1_IDX) begin
          next_st.dat[M1_VREF] = st.reference_power_on;
          next_st.dat[M1_IDLE] = st.idle_operate_sel;
          next_st.dat[M1_EXTEN] = st.ext_trigger_enable;
          next_st.dat[M1_CH_LSB +: CH_W] = st.channel_sel;
        end
      end
      if (wr_acc && idx == MODE0_IDX) begin
        // reserved bits 5:4 are not stored and read back zero
        next_st.repeat_irq_timing = dat_i[M0_ITM];
        next_st.repeat_mode = dat_i[M0_REPEAT];
        next_st.scan_mode = dat_i[M0_SCAN];
      end
      if (wr_acc && idx == MODE1_IDX) begin
        next_st.reference_power_on = dat_i[M1_VREF];
        next_st.idle_operate_sel = dat_i[M1_IDLE];
        next_st.ext_trigger_enable = dat_i[M1_EXTEN];
        next_st.channel_sel = dat_i[M1_CH_LSB +: CH_W];
      end
    end
    // start requests are latched so the mode just written takes effect
    if (sw_start || ext_start) begin
      next_st.go = 1'b1;
    end
    case (st.fsm)
      ASC_IDLE: begin
        if (st.go) begin
          next_st.go = 1'b0;
          next_st.cur = first_ch;
          next_st.conv_busy_flag = 1'b1;
          next_st.conv_end_flag = 1'b0;
          next_st.fsm = ASC_REQ;
        end
      end
      ASC_REQ: begin
        next_st.req = 1'b1;
        next_st.fsm = ASC_WAIT;
      end
      ASC_WAIT: begin
        next_st.go = 1'b0;
        if (done_now) begin
          if (!last_ch) begin
            next_st.cur = next_ch;
            next_st.fsm = ASC_REQ;
            next_st.evt = st.repeat_mode && st.repeat_irq_timing;
          end else if (st.repeat_mode) begin
            next_st.cur = first_ch;
            next_st.fsm = ASC_REQ;
            next_st.conv_end_flag = 1'b1;
            next_st.evt = 1'b1;
          end else begin
            next_st.conv_busy_flag = 1'b0;
            next_st.conv_end_flag = 1'b1;
            next_st.evt = 1'b1;
            next_st.fsm = ASC_IDLE;
          end
        end
      end
      default: begin
        next_st.fsm = ASC_IDLE;
        next_st.conv_busy_flag = 1'b0;
      end
    endcase
    // sleeping without the continue bit ends any conversion
    if (abort_now) begin
      next_st.fsm = ASC_IDLE;
      next_st.conv_busy_flag = 1'b0;
      next_st.go = 1'b0;
      next_st.req = 1'b0;
      next_st.abort = st.fsm != ASC_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st <= '0;
      st.fsm <= ASC_IDLE;
      {st.conv_end_flag, st.conv_busy_flag} <= MODE0_RST[M0_END:M0_BUSY];
      st.repeat_irq_timing <= MODE0_RST[M0_ITM];
      st.repeat_mode <= MODE0_RST[M0_REPEAT];
      st.scan_mode <= MODE0_RST[M0_SCAN];
      st.reference_power_on <= MODE1_RST[M1_VREF];
      st.idle_operate_sel <= MODE1_RST[M1_IDLE];
      st.ext_trigger_enable <= MODE1_RST[M1_EXTEN];
      st.channel_sel <= MODE1_RST[M1_CH_LSB +: CH_W];
    end else begin
      st <= next_st;
    end
  end

  assign dat_o = {24'h00_0000, st.dat};
  assign ack_o = st.ack;
  assign conv_req_o = st.req;
  assign conv_ch_o = st.cur;
  assign conv_abort_o = st.abort;
  assign reference_power_on_o = st.reference_power_on;
  assign conv_end_evt_o = st.evt;
  assign conv_busy_flag_o = st.conv_busy_flag;

  default clocking asc_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  logic idle_go;
  assign idle_go = st.fsm == ASC_IDLE && st.go && !abort_now;

  a_busy_on_start: assert property (idle_go |=> st.conv_busy_flag && !st.conv_end_flag ##1 conv_req_o)
    else $error("start did not raise busy and request");

  a_end_after_last: assert property (done_now && last_ch && !st.repeat_mode
    |=> st.conv_end_flag && !st.conv_busy_flag && conv_end_evt_o)
    else $error("end flag not set after last conversion");

  a_repeat_restart: assert property (done_now && last_ch && st.repeat_mode
    |=> conv_ch_o == $past(first_ch) ##1 conv_req_o)
    else $error("repeat did not restart the sequence");

  a_itm_event: assert property (done_now && !last_ch
    |=> conv_end_evt_o == $past(st.repeat_mode && st.repeat_irq_timing))
    else $error("repeat event timing wrong");

  a_scan_next: assert property (done_now && !last_ch |=> conv_ch_o == $past(st.cur) + 3'h1)
    else $error("scan did not advance to next input");

  a_scan_first: assert property (idle_go && st.scan_mode
    |=> conv_ch_o == {$past(st.channel_sel[2]), 2'b00})
    else $error("scan began at wrong input");

  a_fixed_chan: assert property (idle_go && !st.scan_mode
    |=> conv_ch_o == $past(st.channel_sel) ##2 !conv_req_o)
    else $error("fixed mode input wrong");

  a_top_scan_len: assert property (done_now && st.scan_mode && st.channel_sel == 3'h7 && st.cur == 3'h4
    |=> conv_ch_o == 3'h5)
    else $error("highest code scan order wrong");

  a_vref_follow: assert property (wr_acc && idx == MODE1_IDX
    |=> reference_power_on_o == $past(dat_i[M1_VREF]))
    else $error("reference control not written");

  a_idle_abort: assert property (abort_now |=> !conv_busy_flag_o && !conv_req_o ##1 !conv_req_o)
    else $error("sleep did not abort conversion");

  a_ext_gated: assert property (st.fsm == ASC_IDLE && !st.go && !st.ext_trigger_enable && !sw_start
    |=> !st.go)
    else $error("external trigger started while disabled");

  a_store_flag: assert property (done_now |=> ##1 res_stored[$past(st.cur[1:0], 2)])
    else $error("stored indicator not set");

  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_req_pulse: assert property (conv_req_o |=> !conv_req_o)
    else $error("conversion request held longer than one cycle");

  a_idle_no_req: assert property (st.fsm == ASC_IDLE |-> !conv_req_o)
    else $error("conversion request while idle");

  a_evt_pulse: assert property (conv_end_evt_o |=> !conv_end_evt_o)
    else $error("end event held longer than one cycle");

  a_abort_pulse: assert property (conv_abort_o |=> !conv_abort_o && !conv_busy_flag_o)
    else $error("abort pulse wrong");

  a_ack_answer: assert property (cyc_i && stb_i && !ack_o && !st.pend |=> ##1 ack_o)
    else $error("bus access not answered in two cycles");

  a_low_layout: assert property (rd_acc && is_res && !idx[0] |=> ack_o && dat_o[5:1] == 5'h00)
    else $error("low result register layout wrong");

  a_mode0_read: assert property (rd_acc && idx == MODE0_IDX |=> dat_o[5:4] == 2'b00 && !dat_o[M0_START])
    else $error("start or reserved bits read back set");

  a_ext_start: assert property (ext_start && st.fsm == ASC_IDLE && !st.go && !abort_now |=> st.go)
    else $error("enabled external trigger did not start");

  a_read_clear: assert property (clr_en && !(store_en && st.cur[1:0] == pair)
    |=> !res_stored[$past(pair)])
    else $error("stored indicator not cleared by high read");

  c_single_conv: cover property (idle_go && !st.scan_mode ##[1:50] conv_end_evt_o);
  c_scan_top: cover property (idle_go && st.scan_mode && st.channel_sel == 3'h7);
  c_repeat_wrap: cover property (done_now && last_ch && st.repeat_mode);
  c_sleep_abort: cover property (abort_now && st.fsm == ASC_WAIT);
  c_ext_start: cover property (ext_start && st.fsm == ASC_IDLE);

endmodule : asc_ctrl

// ---- asc_pkg.sv ----
package asc_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] RES0_LOW_IDX = 10'h2a0;
  localparam logic [9:0] RES0_HIGH_IDX = 10'h2a1;
  localparam logic [9:0] RES1_LOW_IDX = 10'h2a2;
  localparam logic [9:0] RES1_HIGH_IDX = 10'h2a3;
  localparam logic [9:0] RES2_LOW_IDX = 10'h2a4;
  localparam logic [9:0] RES2_HIGH_IDX = 10'h2a5;
  localparam logic [9:0] RES3_LOW_IDX = 10'h2a6;
  localparam logic [9:0] RES3_HIGH_IDX = 10'h2a7;
  localparam logic [9:0] MODE0_IDX = 10'h2b0;
  localparam logic [9:0] MODE1_IDX = 10'h2b1;

  localparam int ADR_W = 12;
  localparam int RES_W = 10;
  localparam int PAIRS = 4;
  localparam int CH_W = 3;

  localparam logic [7:0] MODE0_RST = 8'h00;
  localparam logic [7:0] MODE1_RST = 8'h00;

  // conversion_mode_control fields
  localparam int M0_END = 7;
  localparam int M0_BUSY = 6;
  localparam int M0_ITM = 3;
  localparam int M0_REPEAT = 2;
  localparam int M0_SCAN = 1;
  localparam int M0_START = 0;

  // channel_reference_control fields
  localparam int M1_VREF = 7;
  localparam int M1_IDLE = 6;
  localparam int M1_EXTEN = 3;
  localparam int M1_CH_LSB = 0;

  // result_pairN_low layout
  localparam int LOW_LSB_POS = 6;
  localparam int LOW_STORED = 0;

  typedef enum logic [2:0] {
    ASC_IDLE = 3'b001,
    ASC_REQ = 3'b010,
    ASC_WAIT = 3'b100
  } asc_fsm_t;

endpackage : asc_pkg

// ---- asc_result_store.sv ----
`timescale 1ns/1ns
module asc_result_store
  import asc_pkg::*;
#(
  parameter int WIDTH = asc_pkg::RES_W,
  parameter int DEPTH = asc_pkg::PAIRS
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic wr_en_i,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic clr_en_i,
  input wire logic [$clog2(DEPTH)-1:0] clr_idx_i,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
  output logic [WIDTH-1:0] rd_data_o,
  output logic [DEPTH-1:0] stored_o
);
  import asc_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [DEPTH-1:0] stored;
    logic [WIDTH-1:0] rd;
  } asc_store_t;

  asc_store_t st;
  asc_store_t next_st;

  // store wins over a same-cycle clear of the stored indicator
  always_comb begin
    next_st = st;
    next_st.rd = st.mem[rd_idx_i];
    for (int i = 0; i < DEPTH; i++) begin
      if (clr_en_i && clr_idx_i == i) next_st.stored[i] = 1'b0;
      if (wr_en_i && wr_idx_i == i) begin
        next_st.mem[i] = wr_data_i;
        next_st.stored[i] = 1'b1;
      end
    end
  end

  // result contents are left unreset
  always_ff @(posedge clk_sys_i) begin
    st <= next_st;
    if (srst_i) st.stored <= '0;
  end

  assign rd_data_o = st.rd;
  assign stored_o = st.stored;

endmodule : asc_result_store

// ---- asc_scan_step.sv ----
`timescale 1ns/1ns
module asc_scan_step
  import asc_pkg::*;
(
  input wire logic [asc_pkg::CH_W-1:0] ch_i,
  input wire logic scan_i,
  input wire logic [asc_pkg::CH_W-1:0] cur_i,
  output logic [asc_pkg::CH_W-1:0] first_o,
  output logic [asc_pkg::CH_W-1:0] next_o,
  output logic last_o
);
  import asc_pkg::*;

  // scan groups start at input 0 or input 4 and climb to the selected input
  always_comb begin
    first_o = scan_i ? {ch_i[CH_W-1], {(CH_W-1){1'b0}}} : ch_i;
    next_o = CH_W'(cur_i + 1'b1);
    last_o = !scan_i || (cur_i == ch_i);
  end

endmodule : asc_scan_step
